// ===== common/bsse_pkg.sv
// shared constants and types of the burner sequence status encoder
// assumes a single 250 MHz clock and interlock inputs already synchronous to it
package bsse_pkg;

	localparam longint unsigned CLK_FREQ_HZ = 64'd250_000_000;
	localparam longint unsigned CYC_PER_MS  = CLK_FREQ_HZ / 64'd1000;
	localparam int unsigned     TIMER_W     = 40;

	// sequence period lengths in milliseconds
	localparam longint unsigned PRE_TEST_TIME_MS    = 64'd10;
	localparam longint unsigned AIRFLOW_TIME_MS     = 64'd10000;
	localparam longint unsigned PURGE_TIME_MS       = 64'd30000;
	localparam longint unsigned LOW_FIRE_TIME_MS    = 64'd5000;
	localparam longint unsigned PILOT_TRIAL_TIME_MS = 64'd10000;
	localparam longint unsigned MAIN_TRIAL_TIME_MS  = 64'd10000;
	localparam longint unsigned POST_PURGE_TIME_MS  = 64'd15000;
	localparam longint unsigned POST_TEST_TIME_MS   = 64'd10;
	localparam longint unsigned FALSE_FLAME_TIME_MS = 64'd60000;

	// sequence-state codes
	localparam logic [7:0] CODE_PRE_TEST    = 8'h45;
	localparam logic [7:0] CODE_AIRFLOW     = 8'h46;
	localparam logic [7:0] CODE_PURGE       = 8'h47;
	localparam logic [7:0] CODE_LOW_FIRE    = 8'h48;
	localparam logic [7:0] CODE_PILOT_TRIAL = 8'h49;
	localparam logic [7:0] CODE_MAIN_TRIAL  = 8'h4A;
	localparam logic [7:0] CODE_RUN         = 8'h4B;
	localparam logic [7:0] CODE_POST_PURGE  = 8'h4C;
	localparam logic [7:0] CODE_POST_TEST   = 8'h4D;
	localparam logic [7:0] CODE_STANDBY     = 8'h4E;

	// message numbers
	localparam logic [7:0] MSG_OP_CTRL_OPEN   = 8'h01;
	localparam logic [7:0] MSG_FALSE_FLAME    = 8'h02;
	localparam logic [7:0] MSG_LOW_FIRE_PURGE = 8'h03;
	localparam logic [7:0] MSG_AIRFLOW_OPEN   = 8'h05;
	localparam logic [7:0] MSG_FLAME_FAIL     = 8'h07;
	localparam logic [7:0] MSG_CHECK_ADDRESS  = 8'h08;
	localparam logic [7:0] MSG_LOW_LIMIT_OPEN = 8'h09;
	localparam logic [7:0] MSG_IGNITION       = 8'h0A;
	localparam logic [7:0] MSG_FLAME_RUN      = 8'h0C;
	localparam logic [7:0] MSG_CYCLE_DONE     = 8'h0D;
	localparam logic [7:0] MSG_HIGH_PURGE     = 8'h18;
	localparam logic [7:0] MSG_FLAME_MAIN     = 8'h24;
	localparam logic [7:0] MSG_EXP_LOCK_BASE  = 8'h28;
	localparam logic [7:0] MSG_EXP_LOCK_LAST  = 8'h35;
	localparam logic [7:0] MSG_DIAG_BASE      = 8'h36;
	localparam logic [7:0] MSG_DIAG_LAST      = 8'h3B;
	localparam logic [7:0] MSG_EXP_HOLD_BASE  = 8'h3C;
	localparam logic [7:0] MSG_EXP_HOLD_LAST  = 8'h4B;
	localparam logic [7:0] MSG_CHECK_SCANNER  = 8'h4C;
	localparam logic [7:0] MSG_PURGE_IL_LAST  = 8'h52;
	localparam logic [7:0] MSG_AIRFLOW_LOCK   = 8'h28;

	localparam int unsigned EXP_LOCK_N = 14;
	localparam int unsigned DIAG_N     = 6;
	localparam int unsigned EXP_HOLD_N = 16;

	typedef enum logic [1:0] {CAT_RUN, CAT_HOLD, CAT_CHECK, CAT_LOCKOUT} bsse_cat_t;

	typedef struct packed {
		logic opCtrl;
		logic airflow;
		logic lowFireSw;
		logic flame;
		logic resetReq;
		logic addrAttention;
	} bsse_inputs_t;

	typedef struct packed {
		logic blower;
		logic driveHighFire;
		logic ignition;
		logic pilotValve;
		logic mainValve;
		logic alarm;
	} bsse_relays_t;

endpackage

// ===== src/bsse_timer.sv
// down-counting period timer of the sequencer
// assumes load is a one-cycle request with a value of at least one
`timescale 1ns/10ps
module bsse_timer
	import bsse_pkg::*;
#(
	parameter int unsigned W = TIMER_W
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rstN,
	// control
	input  wire logic         load,
	input  wire logic [W-1:0] loadValue,
	// status
	output logic              expired
);
	logic [W-1:0] count_reg;

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			count_reg <= '0;
		end else if (load) begin
			count_reg <= loadValue - W'(1);
		end else if (count_reg != '0) begin
			count_reg <= count_reg - W'(1);
		end
	end

	// expired rises loadValue cycles after the load (two cycles for a loadValue of one) and holds until the next load
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			expired <= 1'b0;
		end else begin
			expired <= !load && (count_reg <= W'(1));
		end
	end
endmodule

// ===== src/bsse_msg_class.sv
// maps a message number onto its run, hold, check or lockout category
// assumes code is steady for at least one cycle; category follows one cycle later
`timescale 1ns/10ps
module bsse_msg_class
	import bsse_pkg::*;
(
	// clock and reset
	input  wire logic  clk,
	input  wire logic  rstN,
	// message in, category out
	input  wire logic [7:0] code,
	output bsse_cat_t  category
);
	function automatic bsse_cat_t classify(input logic [7:0] c);
		bsse_cat_t r;
		r = CAT_CHECK;
		unique case (c) inside
			8'h01, 8'h03, 8'h0A, 8'h0C, 8'h0D, 8'h19, 8'h22, 8'h24, 8'h52: r = CAT_RUN;
			8'h02, 8'h04, 8'h05, 8'h09, 8'h17, 8'h18, 8'h26,
			8'h4D, 8'h4F:                                                  r = CAT_HOLD;
			8'h06, 8'h07, 8'h0F, 8'h4C, 8'h4E, 8'h50, 8'h51:               r = CAT_LOCKOUT;
			[MSG_EXP_LOCK_BASE:MSG_DIAG_LAST]:                             r = CAT_LOCKOUT;
			[MSG_EXP_HOLD_BASE:MSG_EXP_HOLD_LAST]:                         r = CAT_HOLD;
			default:                                                       r = CAT_CHECK;
		endcase
		return r;
	endfunction

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			category <= CAT_RUN;
		end else begin
			category <= classify(code); // R12
		end
	end
endmodule

// ===== src/bsse_top.sv
// burner sequencer with sequence-state code, displayed message and lockout message
// assumes all interlock and scanner inputs are synchronous to clk
`timescale 1ns/10ps

// Overview of operation
// R1: standby code 4EH while operating control open or lockout awaits reset
// R2: code 46H while waiting for air-flow switch; hold until closed or lockout
// R3: false flame in purge returns to standby until flame ceases or lockout
// R4: code 47H during open-damper high-fire purge
// R5: code 48H during low-fire start before pilot light-off
// R6: code 49H during pilot trial for ignition
// R7: code 4AH during main-flame trial
// R8: code 4BH during run period
// R9: code 4CH during post purge and cool-down after lockout
// R10: code 45H for pre-cycle test, 4DH for post-cycle test
// R11: displayed and stored lockout messages are numbers
// R12: every message number carries a run, hold, check or lockout category
// R13: expansion interlock lockouts use numbers 40 to 53
// R14: self-diagnostic lockouts use numbers 54 to 59
// R15: open expansion interlock holds use numbers 60 to 75
// R16: purge interlock conditions use numbers 76 to 82
// R17: unit address attention shows message 8, check category
// R18: sequence-state code is for diagnostics only
// R19: sequence-state code changes in the same cycle as the sequencer
module bsse_top
	import bsse_pkg::*;
#(
	parameter longint unsigned PRE_TEST_CYC    = PRE_TEST_TIME_MS * CYC_PER_MS,
	parameter longint unsigned AIRFLOW_CYC     = AIRFLOW_TIME_MS * CYC_PER_MS,
	parameter longint unsigned PURGE_CYC       = PURGE_TIME_MS * CYC_PER_MS,
	parameter longint unsigned LOW_FIRE_CYC    = LOW_FIRE_TIME_MS * CYC_PER_MS,
	parameter longint unsigned PILOT_TRIAL_CYC = AIRFLOW_CYC * PILOT_TRIAL_TIME_MS / AIRFLOW_TIME_MS,
	parameter longint unsigned MAIN_TRIAL_CYC  = AIRFLOW_CYC * MAIN_TRIAL_TIME_MS / AIRFLOW_TIME_MS,
	parameter longint unsigned POST_PURGE_CYC  = PURGE_CYC * POST_PURGE_TIME_MS / PURGE_TIME_MS,
	parameter longint unsigned POST_TEST_CYC   = PRE_TEST_CYC * POST_TEST_TIME_MS / PRE_TEST_TIME_MS,
	parameter longint unsigned FALSE_FLAME_CYC = FALSE_FLAME_TIME_MS * CYC_PER_MS
) (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  nrst,
	// interlocks and scanner
	input  wire bsse_inputs_t          in,
	input  wire logic [EXP_LOCK_N-1:0] expLockout,
	input  wire logic [DIAG_N-1:0]     diagFault,
	input  wire logic [EXP_HOLD_N-1:0] expHoldOpen,
	// relays
	output bsse_relays_t               relays_reg,
	// status words
	output logic [7:0]                 seqStateCode_reg,
	output logic [7:0]                 displayMessageNumber_reg,
	output bsse_cat_t                  displayCategory,
	output logic [7:0]                 lockoutMessage_reg,
	output bsse_cat_t                  lockoutCategory,
	output logic                       lockout_reg
);
	typedef enum logic [3:0] {
		ST_STANDBY, ST_PRE_TEST, ST_AIRFLOW_WAIT, ST_PURGE, ST_LOW_FIRE,
		ST_PILOT_TRIAL, ST_MAIN_TRIAL, ST_RUN, ST_POST_PURGE, ST_POST_TEST
	} bsse_state_t;

	localparam longint unsigned TMAX = 64'd1 << TIMER_W;

	if (PRE_TEST_CYC < 1 || AIRFLOW_CYC < 1 || PURGE_CYC < 1 || LOW_FIRE_CYC < 1 ||
		PILOT_TRIAL_CYC < 1 || MAIN_TRIAL_CYC < 1 || POST_PURGE_CYC < 1 ||
		POST_TEST_CYC < 1 || FALSE_FLAME_CYC < 1) begin : g_min_check
		$error("period counts must be at least one cycle");
	end
	if (PURGE_CYC >= TMAX || FALSE_FLAME_CYC >= TMAX || POST_PURGE_CYC >= TMAX ||
		AIRFLOW_CYC >= TMAX || PILOT_TRIAL_CYC >= TMAX || MAIN_TRIAL_CYC >= TMAX ||
		LOW_FIRE_CYC >= TMAX || PRE_TEST_CYC >= TMAX ||
		POST_TEST_CYC >= TMAX) begin : g_max_check
		$error("period count exceeds timer width");
	end

	logic              rstMeta;
	logic              rstSyncN;
	bsse_state_t       state_reg;
	bsse_state_t       state_next;
	logic              falseFlame_reg;
	logic              falseFlame_next;
	logic              lockout_next;
	logic              lockoutEvt;
	logic [7:0]        lockoutCode;
	logic [7:0]        message_next;
	logic              timerLoad;
	logic [TIMER_W-1:0] timerValue;
	logic              timerExpired;
	logic              startOk;

	function automatic logic [7:0] stateCode(input bsse_state_t s);
		logic [7:0] c;
		c = CODE_STANDBY;
		unique case (s)
			ST_STANDBY:     c = CODE_STANDBY;
			ST_PRE_TEST:    c = CODE_PRE_TEST;
			ST_AIRFLOW_WAIT: c = CODE_AIRFLOW;
			ST_PURGE:       c = CODE_PURGE; // R4
			ST_LOW_FIRE:    c = CODE_LOW_FIRE; // R5
			ST_PILOT_TRIAL: c = CODE_PILOT_TRIAL; // R6
			ST_MAIN_TRIAL:  c = CODE_MAIN_TRIAL; // R7
			ST_RUN:         c = CODE_RUN; // R8
			ST_POST_PURGE:  c = CODE_POST_PURGE;
			ST_POST_TEST:   c = CODE_POST_TEST;
		endcase
		return c;
	endfunction

	// reset release through two flip-flops
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rstMeta  <= 1'b0;
			rstSyncN <= 1'b0;
		end else begin
			rstMeta  <= 1'b1;
			rstSyncN <= rstMeta;
		end
	end

	// lockout source selection: diagnostics first, then expansion, then sequence faults
	always_comb begin
		lockoutEvt  = 1'b0;
		lockoutCode = MSG_FLAME_FAIL;
		if (!lockout_reg) begin
			if ((state_reg == ST_PILOT_TRIAL && timerExpired && !in.flame) ||
				((state_reg == ST_MAIN_TRIAL || state_reg == ST_RUN) && !in.flame)) begin
				lockoutEvt  = 1'b1;
				lockoutCode = MSG_FLAME_FAIL;
			end
			if (state_reg == ST_AIRFLOW_WAIT && timerExpired && !in.airflow) begin
				lockoutEvt  = 1'b1;
				lockoutCode = MSG_AIRFLOW_LOCK;
			end
			if (state_reg == ST_STANDBY && falseFlame_reg && in.flame && timerExpired) begin
				lockoutEvt  = 1'b1;
				lockoutCode = MSG_CHECK_SCANNER; // R16
			end
			for (int i = EXP_LOCK_N - 1; i >= 0; i--) begin
				if (expLockout[i]) begin
					lockoutEvt  = 1'b1;
					lockoutCode = MSG_EXP_LOCK_BASE + 8'(i); // R13
				end
			end
			for (int i = DIAG_N - 1; i >= 0; i--) begin
				if (diagFault[i]) begin
					lockoutEvt  = 1'b1;
					lockoutCode = MSG_DIAG_BASE + 8'(i); // R14
				end
			end
		end
	end

	assign startOk = !lockout_reg && in.opCtrl && !in.flame && !falseFlame_reg &&
		expHoldOpen == '0;

	// sequencer transitions
	always_comb begin
		state_next      = state_reg;
		falseFlame_next = falseFlame_reg && in.flame && !lockoutEvt; // R3
		unique case (state_reg)
			ST_STANDBY:      if (startOk) state_next = ST_PRE_TEST; // R1
			ST_PRE_TEST:     if (timerExpired) state_next = ST_AIRFLOW_WAIT;
			ST_AIRFLOW_WAIT: if (in.airflow) state_next = ST_PURGE; // R2
			ST_PURGE: begin
				if (in.flame) begin
					state_next      = ST_STANDBY; // R3
					falseFlame_next = 1'b1;
				end else if (timerExpired) begin
					state_next = ST_LOW_FIRE;
				end
			end
			ST_LOW_FIRE:     if (timerExpired && in.lowFireSw) state_next = ST_PILOT_TRIAL;
			ST_PILOT_TRIAL:  if (timerExpired && in.flame) state_next = ST_MAIN_TRIAL;
			ST_MAIN_TRIAL:   if (timerExpired) state_next = ST_RUN;
			ST_RUN:          if (!in.opCtrl) state_next = ST_POST_PURGE;
			ST_POST_PURGE: begin
				if (timerExpired) begin
					state_next = lockout_reg ? ST_STANDBY : ST_POST_TEST; // R9
				end
			end
			ST_POST_TEST:    if (timerExpired) state_next = ST_STANDBY;
		endcase
		if (lockoutEvt && state_reg != ST_STANDBY) begin
			state_next = ST_POST_PURGE; // R9
		end
	end

	// a reset request in standby clears the lockout even with a source still active; that source locks out again one cycle later
	assign lockout_next = lockoutEvt ||
		(lockout_reg && !(in.resetReq && state_reg == ST_STANDBY));

	// timer reload on every state change, lockout or false-flame entry
	assign timerLoad = state_next != state_reg || lockoutEvt ||
		(falseFlame_next && !falseFlame_reg);

	always_comb begin
		timerValue = TIMER_W'(1);
		unique case (state_next)
			ST_STANDBY:      timerValue = TIMER_W'(FALSE_FLAME_CYC);
			ST_PRE_TEST:     timerValue = TIMER_W'(PRE_TEST_CYC);
			ST_AIRFLOW_WAIT: timerValue = TIMER_W'(AIRFLOW_CYC);
			ST_PURGE:        timerValue = TIMER_W'(PURGE_CYC);
			ST_LOW_FIRE:     timerValue = TIMER_W'(LOW_FIRE_CYC);
			ST_PILOT_TRIAL:  timerValue = TIMER_W'(PILOT_TRIAL_CYC);
			ST_MAIN_TRIAL:   timerValue = TIMER_W'(MAIN_TRIAL_CYC);
			ST_RUN:          timerValue = TIMER_W'(1);
			ST_POST_PURGE:   timerValue = TIMER_W'(POST_PURGE_CYC);
			ST_POST_TEST:    timerValue = TIMER_W'(POST_TEST_CYC);
		endcase
	end

	bsse_timer #(
		.W (TIMER_W)
	) u_timer (
		.clk       (clk),
		.rstN      (rstSyncN),
		.load      (timerLoad),
		.loadValue (timerValue),
		.expired   (timerExpired)
	);

	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			state_reg <= ST_STANDBY;
		end else begin
			state_reg <= state_next;
		end
	end

	// state code loaded from the same next value as the sequencer; diagnostic only
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			seqStateCode_reg <= CODE_STANDBY;
		end else begin
			seqStateCode_reg <= stateCode(state_next); // R19 R18 R10
		end
	end

	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			falseFlame_reg     <= 1'b0;
			lockout_reg        <= 1'b0;
			lockoutMessage_reg <= 8'h00;
		end else begin
			falseFlame_reg <= falseFlame_next;
			lockout_reg    <= lockout_next;
			if (lockoutEvt) begin
				lockoutMessage_reg <= lockoutCode; // R11
			end
		end
	end

	// displayed message, highest priority first
	always_comb begin
		message_next = MSG_OP_CTRL_OPEN;
		if (lockout_reg) begin
			message_next = lockoutMessage_reg;
		end else if (in.addrAttention) begin
			message_next = MSG_CHECK_ADDRESS; // R17
		end else begin
			unique case (state_reg)
				ST_STANDBY: begin
					message_next = MSG_OP_CTRL_OPEN;
					if (falseFlame_reg) begin
						message_next = MSG_FALSE_FLAME;
					end else if (in.opCtrl) begin
						for (int i = EXP_HOLD_N - 1; i >= 0; i--) begin
							if (expHoldOpen[i]) begin
								message_next = MSG_EXP_HOLD_BASE + 8'(i); // R15
							end
						end
					end
				end
				ST_PRE_TEST:     message_next = MSG_OP_CTRL_OPEN;
				ST_AIRFLOW_WAIT: message_next = MSG_AIRFLOW_OPEN;
				ST_PURGE:        message_next = MSG_HIGH_PURGE;
				ST_LOW_FIRE: begin
					message_next = in.lowFireSw ? MSG_LOW_FIRE_PURGE : MSG_LOW_LIMIT_OPEN;
				end
				ST_PILOT_TRIAL:  message_next = MSG_IGNITION;
				ST_MAIN_TRIAL:   message_next = MSG_FLAME_MAIN;
				ST_RUN:          message_next = MSG_FLAME_RUN;
				ST_POST_PURGE:   message_next = MSG_CYCLE_DONE;
				ST_POST_TEST:    message_next = MSG_CYCLE_DONE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			displayMessageNumber_reg <= MSG_OP_CTRL_OPEN;
		end else begin
			displayMessageNumber_reg <= message_next; // R11
		end
	end

	bsse_msg_class u_disp_class (
		.clk      (clk),
		.rstN     (rstSyncN),
		.code     (displayMessageNumber_reg),
		.category (displayCategory)
	);

	bsse_msg_class u_lock_class (
		.clk      (clk),
		.rstN     (rstSyncN),
		.code     (lockoutMessage_reg),
		.category (lockoutCategory)
	);

	// relays other than alarm follow the next state so they switch with the state code; alarm follows lockout_next
	always_ff @(posedge clk or negedge rstSyncN) begin
		if (!rstSyncN) begin
			relays_reg <= '0;
		end else begin
			relays_reg.blower        <= state_next != ST_STANDBY && state_next != ST_PRE_TEST;
			relays_reg.driveHighFire <= state_next == ST_AIRFLOW_WAIT || state_next == ST_PURGE;
			relays_reg.ignition      <= state_next == ST_PILOT_TRIAL || state_next == ST_MAIN_TRIAL;
			relays_reg.pilotValve    <= state_next == ST_PILOT_TRIAL || state_next == ST_MAIN_TRIAL;
			relays_reg.mainValve     <= state_next == ST_MAIN_TRIAL || state_next == ST_RUN;
			relays_reg.alarm         <= lockout_next;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstSyncN);

	sequence sLockoutInCycle;
		lockoutEvt && state_reg != ST_STANDBY;
	endsequence

	sequence sCoolDown;
		state_reg == ST_POST_PURGE && seqStateCode_reg == CODE_POST_PURGE && lockout_reg;
	endsequence

	a_standby_code: assert property (state_reg == ST_STANDBY |->  // R1
		seqStateCode_reg == 8'h4E) else $error("standby code wrong");
	a_airflow_hold: assert property (state_reg == ST_AIRFLOW_WAIT && !in.airflow &&  // R2
		!lockoutEvt |=> state_reg == ST_AIRFLOW_WAIT && seqStateCode_reg == 8'h46)
		else $error("air-flow wait left early");
	a_false_flame_back: assert property (state_reg == ST_PURGE && in.flame &&  // R3
		!lockoutEvt |=> state_reg == ST_STANDBY ##1 seqStateCode_reg == 8'h4E)
		else $error("false flame did not return to standby");
	a_purge_code: assert property (state_reg == ST_PURGE |->  // R4
		seqStateCode_reg == 8'h47 && relays_reg.driveHighFire)
		else $error("purge code wrong");
	a_low_fire_code: assert property (state_reg == ST_LOW_FIRE |->  // R5
		seqStateCode_reg == 8'h48) else $error("low fire code wrong");
	a_pilot_code: assert property (state_reg == ST_PILOT_TRIAL |->  // R6
		seqStateCode_reg == 8'h49 && relays_reg.pilotValve) else $error("pilot code wrong");
	a_main_code: assert property (state_reg == ST_MAIN_TRIAL |->  // R7
		seqStateCode_reg == 8'h4A && relays_reg.mainValve) else $error("main trial code wrong");
	a_run_code: assert property (state_reg == ST_RUN |->  // R8
		seqStateCode_reg == 8'h4B) else $error("run code wrong");
	a_cool_down: assert property (sLockoutInCycle |=> sCoolDown)  // R9
		else $error("lockout did not enter cool-down");
	a_test_codes: assert property ((state_reg == ST_PRE_TEST) == (seqStateCode_reg == 8'h45) &&  // R10
		(state_reg == ST_POST_TEST) == (seqStateCode_reg == 8'h4D))
		else $error("test period code wrong");
	a_flame_fail_cat: assert property (lockout_reg && lockoutMessage_reg == 8'h07 &&  // R12
		$stable(lockoutMessage_reg) |=> lockoutCategory == CAT_LOCKOUT)
		else $error("flame fail not lockout category");
	a_exp_lock_range: assert property (!lockout_reg && diagFault == '0 &&  // R13
		expLockout != '0 |=> lockout_reg && lockoutMessage_reg inside {[8'd40:8'd53]})
		else $error("expansion lockout number out of range");
	a_diag_range: assert property (!lockout_reg && diagFault != '0 |=>  // R14
		lockoutMessage_reg inside {[8'd54:8'd59]} ##1 lockoutCategory == CAT_LOCKOUT)
		else $error("diagnostic lockout number out of range");
	a_exp_hold_range: assert property (state_reg == ST_STANDBY && !lockout_reg &&  // R15
		!in.addrAttention && !falseFlame_reg && in.opCtrl && expHoldOpen != '0 |=>
		displayMessageNumber_reg inside {[8'd60:8'd75]}) else $error("hold number out of range");
	a_scanner_lock: assert property (state_reg == ST_STANDBY && falseFlame_reg &&  // R16
		in.flame && timerExpired && !lockout_reg && diagFault == '0 && expLockout == '0 |=>
		lockoutMessage_reg == 8'd76) else $error("scanner lockout number wrong");
	a_address_check: assert property (in.addrAttention && !lockout_reg |=>  // R17
		displayMessageNumber_reg == 8'd8 ##1 displayCategory == CAT_CHECK)
		else $error("address attention not shown");
	a_code_tracks: assert property (seqStateCode_reg == stateCode(state_reg) &&  // R19
		(!$changed(state_reg) || $changed(seqStateCode_reg)))
		else $error("state code lags sequencer");
endmodule

// ===== sim/bsse_plant.sv
// behavioural model of the burner switches and flame scanner
// assumes relays from the sequencer; switch levels follow them one cycle later
`timescale 1ns/10ps
module bsse_plant
	import bsse_pkg::*;
(
	// clock
	input  wire logic   clk,
	// relay drive and bench controls
	input  wire bsse_relays_t relays,
	input  wire logic   airOk,
	input  wire logic   flameEn,
	input  wire logic   falseFlame,
	// switch and scanner levels
	output logic        airflow,
	output logic        lowFireSw,
	output logic        flame
);
	// a stuck switch or a dead scanner is commanded by the bench
	always_ff @(posedge clk) begin
		airflow   <= airOk & relays.blower;
		lowFireSw <= !relays.driveHighFire;
		flame     <= falseFlame | (flameEn & (relays.pilotValve | relays.mainValve));
	end
endmodule

// ===== sim/tb.sv
// self-checking bench of the burner sequence status encoder
// assumes short sequence periods set through the top parameters
`timescale 1ns/10ps
module tb;
	import bsse_pkg::*;
	localparam logic [7:0] SEQ [10] = '{8'h45, 8'h46, 8'h47, 8'h48, 8'h49, 8'h4A, 8'h4B,
		8'h4C, 8'h4D, 8'h4E};
	logic clk, nrst, opCtrl, resetReq, addrAtt, airOk, flameEn, falseFlame;
	logic airflow, lowFireSw, flame, lockout;
	logic [EXP_LOCK_N-1:0] expLockout;
	logic [DIAG_N-1:0]     diagFault;
	logic [EXP_HOLD_N-1:0] expHoldOpen;
	logic [7:0]            code, msg, lockMsg, lastCode;
	logic [7:0]            seen [$];
	bsse_inputs_t          in;
	bsse_relays_t          relays;
	bsse_cat_t             dispCat, lockCat;
	int error_cnt, checks, cyc, r;

	assign in = {opCtrl, airflow, lowFireSw, flame, resetReq, addrAtt};
	bsse_top #(.PRE_TEST_CYC(64'd3), .AIRFLOW_CYC(64'd10), .PURGE_CYC(64'd8),
		.LOW_FIRE_CYC(64'd4), .FALSE_FLAME_CYC(64'd20)) u_dut (
		.clk(clk), .nrst(nrst), .in(in), .expLockout(expLockout), .diagFault(diagFault),
		.expHoldOpen(expHoldOpen), .relays_reg(relays), .seqStateCode_reg(code),
		.displayMessageNumber_reg(msg), .displayCategory(dispCat),
		.lockoutMessage_reg(lockMsg), .lockoutCategory(lockCat), .lockout_reg(lockout));
	bsse_plant u_plant (.clk(clk), .relays(relays), .airOk(airOk), .flameEn(flameEn),
		.falseFlame(falseFlame), .airflow(airflow), .lowFireSw(lowFireSw), .flame(flame));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// records every new state code in order
	always @(posedge clk) begin
		cyc++;
		if (code !== lastCode) begin
			seen.push_back(code);
			lastCode <= code;
		end
		if (cyc == 20000) begin
			error_cnt++;
			test_done();
		end
	end

	task automatic test_done();
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wait_code(input logic [7:0] c);
		int w;
		w = 0;
		while (code !== c && w < 300) begin
			wt(1);
			w++;
		end
		chk(code, c);
	endtask
	task automatic clear_lock();
		@(posedge clk) opCtrl <= 1'b0;
		resetReq <= 1'b1;
		@(posedge clk) resetReq <= 1'b0;
		wt(3);
		chk({7'h00, lockout}, 8'h00);
	endtask

	initial begin
		{nrst, opCtrl, resetReq, addrAtt, falseFlame} = 5'h00;
		{airOk, flameEn} = 2'h3;
		{expLockout, diagFault, expHoldOpen} = '0;
		lastCode = 8'h4E;
		r = $urandom(32'h5470f076);
		wt(8);
		@(posedge clk) nrst <= 1'b1;
		wt(4);
		chk(code, CODE_STANDBY);
		chk(msg, MSG_OP_CTRL_OPEN);
		chk({6'h00, dispCat}, {6'h00, CAT_RUN});
		// full cycle
		seen.delete();
		@(posedge clk) opCtrl <= 1'b1;
		wait_code(CODE_PILOT_TRIAL);
		chk({7'h00, relays.pilotValve}, 8'h01);
		wait_code(CODE_RUN);
		wt(2 + $urandom % 5);
		chk(msg, MSG_FLAME_RUN);
		@(posedge clk) opCtrl <= 1'b0;
		wait_code(CODE_STANDBY);
		wt(1);
		chk(8'(seen.size()), 8'd10);
		foreach (SEQ[k]) chk(seen[k], SEQ[k]);
		// false flame in purge, then pilot flame failure
		@(posedge clk) opCtrl <= 1'b1;
		wait_code(CODE_PURGE);
		@(posedge clk) falseFlame <= 1'b1;
		wt(3);
		chk(code, CODE_STANDBY);
		chk(msg, MSG_FALSE_FLAME);
		@(posedge clk) falseFlame <= 1'b0;
		flameEn <= 1'b0;
		wait_code(CODE_PILOT_TRIAL);
		wait_code(CODE_POST_PURGE);
		chk(lockMsg, MSG_FLAME_FAIL);
		wait_code(CODE_STANDBY);
		chk({6'h00, lockCat}, {6'h00, CAT_LOCKOUT});
		@(posedge clk) flameEn <= 1'b1;
		clear_lock();
		// air flow switch stuck open
		@(posedge clk) airOk <= 1'b0;
		opCtrl <= 1'b1;
		wait_code(CODE_AIRFLOW);
		wt(4);
		chk(code, CODE_AIRFLOW);
		wait_code(CODE_POST_PURGE);
		chk(lockMsg, MSG_AIRFLOW_LOCK);
		wait_code(CODE_STANDBY);
		@(posedge clk) airOk <= 1'b1;
		clear_lock();
		// flame that outlasts the false-flame hold locks out from standby
		@(posedge clk) opCtrl <= 1'b1;
		wait_code(CODE_PURGE);
		@(posedge clk) falseFlame <= 1'b1;
		wt(30);
		chk(lockMsg, MSG_CHECK_SCANNER);
		chk(code, CODE_STANDBY);
		@(posedge clk) falseFlame <= 1'b0;
		clear_lock();
		// random diagnostic and expansion lockouts
		r = $urandom % DIAG_N;
		@(posedge clk) diagFault <= 6'h01 << r;
		wt(3);
		chk(lockMsg, MSG_DIAG_BASE + 8'(r));
		@(posedge clk) diagFault <= '0;
		clear_lock();
		r = $urandom % EXP_LOCK_N;
		@(posedge clk) expLockout <= 14'h0001 << r;
		wt(3);
		chk(lockMsg, MSG_EXP_LOCK_BASE + 8'(r));
		chk({6'h00, lockCat}, {6'h00, CAT_LOCKOUT});
		@(posedge clk) expLockout <= '0;
		clear_lock();
		// open expansion hold blocks start
		r = $urandom % EXP_HOLD_N;
		@(posedge clk) expHoldOpen <= 16'h0001 << r;
		opCtrl <= 1'b1;
		wt(5);
		chk(code, CODE_STANDBY);
		chk(msg, MSG_EXP_HOLD_BASE + 8'(r));
		chk({6'h00, dispCat}, {6'h00, CAT_HOLD});
		@(posedge clk) expHoldOpen <= '0;
		addrAtt <= 1'b1;
		wt(4);
		chk(msg, MSG_CHECK_ADDRESS);
		chk({6'h00, dispCat}, {6'h00, CAT_CHECK});
		@(posedge clk) addrAtt <= 1'b0;
		opCtrl <= 1'b0;
		wait_code(CODE_STANDBY);
		test_done();
	end
endmodule
